// >>> design/sapc_top.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_top
  import sapc_pkg::*;
#(
  parameter int DEPTH = 8
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        por_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        rck_i,
  output logic             rck_o,
  output logic             rck_oe,
  input  wire logic        rfs_i,
  output logic             rfs_o,
  output logic             rfs_oe,
  input  wire logic        tck_i,
  output logic             tck_o,
  output logic             tck_oe,
  input  wire logic        tfs_i,
  output logic             tfs_o,
  output logic             tfs_oe,
  input  wire logic        rxd_i,
  output logic             txd_o,
  output logic             txd_oe,
  output logic             irq_rx_data,
  output logic             irq_rx_exc,
  output logic             irq_tx_data,
  output logic             irq_tx_exc
);
  // The queue pointers are three bits wide, so only eight entries fit.
  if (DEPTH != 8)
  begin : g_depth_check
    $error("sapc_top: DEPTH must be 8");
  end

  typedef struct packed {
    logic [15:0] ctrl2;
    logic [1:0]  ctrl;
    logic [3:0]  rwm;
    logic [3:0]  twm;
    logic [7:0]  div;
    logic [7:0]  divcnt;
    logic        gclk;
    logic [1:0]  s_rck;
    logic [1:0]  s_rfs;
    logic [1:0]  s_tck;
    logic [1:0]  s_tfs;
    logic [1:0]  s_rxd;
    logic        p_rck;
    logic        p_tck;
    logic [15:0] rsh;
    logic [4:0]  rbits;
    logic        rbusy;
    logic        ren_lost;
    logic        rx_run;
    logic [7:0][15:0] rxq;
    logic [2:0]  rwp;
    logic [2:0]  rrp;
    logic [3:0]  rcnt;
    logic [15:0] tsh;
    logic [15:0] tlast;
    logic [4:0]  tbits;
    logic        tbusy;
    logic        tskip;
    logic        tx_run;
    logic [7:0][15:0] txq;
    logic [7:0]  tqskip;
    logic [2:0]  twp;
    logic [2:0]  trp;
    logic [3:0]  tcnt;
    logic        rx_ready_flag;
    logic        rx_overrun_flag;
    logic        tx_underrun_flag;
    logic        roe_seen;
    logic        tue_seen;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rck_o;
    logic        rck_oe;
    logic        rfs_o;
    logic        rfs_oe;
    logic        tck_o;
    logic        tck_oe;
    logic        tfs_o;
    logic        tfs_oe;
    logic        txd_o;
    logic        txd_oe;
    logic [3:0]  irq;
  } sapc_state_t;

  sapc_state_t st_r;
  sapc_state_t st_nxt;
  logic [15:0] ctrl2_r;

  // Power-on reset alone clears port_control_reg_two.
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      ctrl2_r <= CTRL2_RESET;
    else if (psel && penable && pwrite && paddr == ADDR_CTRL2)
      ctrl2_r <= pwdata[15:0];
  end

  // Next-state logic for the whole port.
  always_comb
  begin
    logic pen, syn, gated, bclk, fs, rx_edge, tx_edge, rd_rx, wr_tx, wr_sk;
    logic tx_empty_flag, rx_fifo_full_flag, tx_fifo_low_flag, rfull, tfull, rirq, tirq, acc, tx_fs, roe_set;
    logic tue_set;
    pen = 1'b0; syn = 1'b0; gated = 1'b0; bclk = 1'b0; fs = 1'b0;
    rx_edge = 1'b0; tx_edge = 1'b0; rd_rx = 1'b0; wr_tx = 1'b0;
    wr_sk = 1'b0; tx_empty_flag = 1'b0; rx_fifo_full_flag = 1'b0; tx_fifo_low_flag = 1'b0; rfull = 1'b0;
    tfull = 1'b0; rirq = 1'b0; tirq = 1'b0; acc = 1'b0;
    tx_fs = 1'b0; roe_set = 1'b0; tue_set = 1'b0;
    st_nxt = st_r;
    st_nxt.ctrl2 = ctrl2_r;
    pen = st_r.ctrl[B_PEN];
    syn = ctrl2_r[B_SYN];
    gated = syn & ctrl2_r[B_RX_CLOCK_DIRECTION];
    acc = psel & penable;
    rd_rx = acc & ~pwrite & (paddr == ADDR_RXDATA);
    wr_tx = acc & pwrite & (paddr == ADDR_TXDATA);
    wr_sk = acc & pwrite & (paddr == ADDR_SKIP);
    // Pin synchronisers.
    st_nxt.s_rck = {st_r.s_rck[0], rck_i};
    st_nxt.s_rfs = {st_r.s_rfs[0], rfs_i};
    st_nxt.s_tck = {st_r.s_tck[0], tck_i};
    st_nxt.s_tfs = {st_r.s_tfs[0], tfs_i};
    st_nxt.s_rxd = {st_r.s_rxd[0], rxd_i};
    // Internal bit clock divider; gated clock runs only while tx is enabled or shifting.
    if (st_r.divcnt >= st_r.div)
    begin
      st_nxt.divcnt = 8'h00;
      st_nxt.gclk = ~st_r.gclk;
    end
    else
      st_nxt.divcnt = st_r.divcnt + 8'h01;
    if (gated && !(ctrl2_r[B_TE] || st_r.tbusy))
      st_nxt.gclk = 1'b0;
    // Receive clock source: internal when rx direction set and sync mode is off.
    st_nxt.p_rck = (ctrl2_r[B_RX_CLOCK_DIRECTION] && !syn) ? st_r.gclk : st_r.s_rck[1];
    // Transmit clock source from tx direction bit.
    st_nxt.p_tck = ctrl2_r[B_TX_CLOCK_DIRECTION] ? st_r.gclk : st_r.s_tck[1];
    bclk = syn ? st_nxt.p_tck : st_nxt.p_rck;
    rx_edge = (syn ? st_nxt.p_tck & ~st_r.p_tck
                   : st_nxt.p_rck & ~st_r.p_rck) & pen;
    tx_edge = st_nxt.p_tck & ~st_r.p_tck & pen;
    fs = syn ? (ctrl2_r[B_TX_FRAMESYNC_DIRECTION] ? ~st_r.tbusy : st_r.s_tfs[1])
             : (ctrl2_r[B_RX_FRAMESYNC_DIRECTION] ? ~st_r.rbusy : st_r.s_rfs[1]);
    // The transmitter takes its own frame sync, except in gated mode, which forces it high.
    tx_fs = ctrl2_r[B_TX_FRAMESYNC_DIRECTION] ? ~st_r.tbusy : st_r.s_tfs[1];
    if (gated)
    begin
      fs = 1'b1;
      tx_fs = 1'b1;
    end
    rfull = ctrl2_r[B_RX_FIFO_ON] ? (st_r.rcnt == 4'(DEPTH)) : st_r.rx_ready_flag;
    tfull = ctrl2_r[B_TX_FIFO_ON] ? (st_r.tcnt == 4'(DEPTH)) : (st_r.tcnt != 0);
    // Receive shifter: start at frame sync, drop word when disabled on its last two bit edges.
    if (rx_edge)
    begin
      if (!st_r.rbusy && fs && ctrl2_r[B_RE])
      begin
        st_nxt.rbusy = 1'b1;
        st_nxt.rbits = 5'h01;
        st_nxt.rsh = {15'h0000, st_r.s_rxd[1]};
        st_nxt.ren_lost = 1'b0;
      end
      else if (st_r.rbusy)
      begin
        if (!ctrl2_r[B_RE] && st_r.rbits >= WORD_BITS - 5'h02)
          st_nxt.ren_lost = 1'b1;
        if (ctrl2_r[B_RE])
          st_nxt.rsh = {st_r.rsh[14:0], st_r.s_rxd[1]};
        st_nxt.rbits = st_r.rbits + 5'h01;
        if (st_r.rbits == WORD_BITS - 5'h01)
        begin
          st_nxt.rbusy = 1'b0;
          if (ctrl2_r[B_RE] && !st_r.ren_lost)
          begin
            if (rfull)
            begin
              st_nxt.rx_overrun_flag = 1'b1;
              roe_set = 1'b1;
            end
            else
            begin
              st_nxt.rxq[st_r.rwp] = {st_r.rsh[14:0], st_r.s_rxd[1]};
              st_nxt.rwp = ctrl2_r[B_RX_FIFO_ON] ? st_r.rwp + 3'h1 : 3'h0;
              st_nxt.rcnt = st_r.rcnt + 4'h1;
              st_nxt.rx_ready_flag = 1'b1;
            end
          end
        end
      end
    end
    // Data register read pops the receive queue.
    if (rd_rx && st_r.rcnt != 0)
    begin
      st_nxt.rrp = ctrl2_r[B_RX_FIFO_ON] ? st_r.rrp + 3'h1 : 3'h0;
      st_nxt.rcnt = st_nxt.rcnt - 4'h1;
      if (!(rx_edge && st_nxt.rx_ready_flag && !st_r.rx_ready_flag) && st_nxt.rcnt == 0)
        st_nxt.rx_ready_flag = 1'b0;
      if (st_r.roe_seen)
      begin
        // A new overrun in the same cycle wins over the clear.
        st_nxt.rx_overrun_flag = roe_set;
        st_nxt.roe_seen = 1'b0;
      end
    end
    // Transmit side: frame boundary activation and shifting.
    if (ctrl2_r[B_TE] && !st_r.tx_run && !st_r.tbusy)
      st_nxt.tx_run = 1'b1;
    if (!ctrl2_r[B_TE] && !st_r.tbusy)
      st_nxt.tx_run = 1'b0;
    if (tx_edge)
    begin
      if (st_r.tbusy)
      begin
        st_nxt.tsh = {st_r.tsh[14:0], 1'b0};
        st_nxt.tbits = st_r.tbits + 5'h01;
        if (st_r.tbits == WORD_BITS - 5'h01)
          st_nxt.tbusy = 1'b0;
      end
      else if (st_r.tx_run && ctrl2_r[B_TE] && tx_fs)
      begin
        st_nxt.tbusy = 1'b1;
        st_nxt.tbits = 5'h01;
        if (st_r.tcnt == 0)
        begin
          st_nxt.tx_underrun_flag = 1'b1;
          tue_set = 1'b1;
          st_nxt.tsh = st_r.tlast;
          st_nxt.tskip = 1'b0;
        end
        else
        begin
          st_nxt.tsh = st_r.txq[st_r.trp];
          st_nxt.tlast = st_r.txq[st_r.trp];
          st_nxt.tskip = st_r.tqskip[st_r.trp];
          st_nxt.trp = ctrl2_r[B_TX_FIFO_ON] ? st_r.trp + 3'h1 : 3'h0;
          st_nxt.tcnt = st_r.tcnt - 4'h1;
        end
      end
    end
    // Data or slot-skip writes fill the transmit queue.
    if ((wr_tx || wr_sk) && !tfull)
    begin
      st_nxt.txq[st_r.twp] = pwdata[15:0];
      st_nxt.tqskip[st_r.twp] = wr_sk;
      st_nxt.twp = ctrl2_r[B_TX_FIFO_ON] ? st_r.twp + 3'h1 : 3'h0;
      st_nxt.tcnt = st_nxt.tcnt + 4'h1;
      if (st_r.tue_seen)
      begin
        // A new underrun in the same cycle wins over the clear.
        st_nxt.tx_underrun_flag = tue_set;
        st_nxt.tue_seen = 1'b0;
      end
    end
    if (acc && !pwrite && paddr == ADDR_STATUS)
    begin
      st_nxt.roe_seen = st_r.rx_overrun_flag;
      st_nxt.tue_seen = st_r.tx_underrun_flag;
    end
    // Port disable clears queues and status, keeps control.
    if (!pen)
    begin
      st_nxt.rcnt = 4'h0; st_nxt.tcnt = 4'h0; st_nxt.rwp = 3'h0;
      st_nxt.rrp = 3'h0; st_nxt.twp = 3'h0; st_nxt.trp = 3'h0;
      st_nxt.rx_ready_flag = 1'b0; st_nxt.rx_overrun_flag = 1'b0; st_nxt.tx_underrun_flag = 1'b0;
      st_nxt.rbusy = 1'b0; st_nxt.tbusy = 1'b0; st_nxt.tx_run = 1'b0;
    end
    // Flags and interrupts.
    tx_empty_flag = ~tfull;
    rx_fifo_full_flag = ctrl2_r[B_RX_FIFO_ON] & (st_r.rcnt >= st_r.rwm);
    tx_fifo_low_flag = ctrl2_r[B_TX_FIFO_ON] & (st_r.tcnt < st_r.twm);
    rirq = ctrl2_r[B_RIE] & ctrl2_r[B_RE] & st_r.ctrl[B_IPRE]
         & (ctrl2_r[B_RX_FIFO_ON] ? rx_fifo_full_flag : st_r.rx_ready_flag);
    tirq = ctrl2_r[B_TIE] & ctrl2_r[B_TE] & st_r.ctrl[B_IPRE]
         & (ctrl2_r[B_TX_FIFO_ON] ? tx_fifo_low_flag : tx_empty_flag);
    st_nxt.irq = {tirq & st_r.tx_underrun_flag, tirq & ~st_r.tx_underrun_flag,
                  rirq & st_r.rx_overrun_flag, rirq & ~st_r.rx_overrun_flag};
    // Pin directions per mode.
    st_nxt.rck_o = st_r.gclk;
    st_nxt.rck_oe = pen & ~syn & ctrl2_r[B_RX_CLOCK_DIRECTION];
    st_nxt.rfs_o = ~st_r.rbusy;
    st_nxt.rfs_oe = pen & ~syn & ctrl2_r[B_RX_FRAMESYNC_DIRECTION];
    st_nxt.tck_o = st_r.gclk;
    st_nxt.tck_oe = pen & (gated ? ctrl2_r[B_TX_CLOCK_DIRECTION] : ctrl2_r[B_TX_CLOCK_DIRECTION]);
    st_nxt.tfs_o = ~st_r.tbusy;
    st_nxt.tfs_oe = pen & ~gated & ctrl2_r[B_TX_FRAMESYNC_DIRECTION];
    st_nxt.txd_o = st_r.tsh[15];
    st_nxt.txd_oe = pen & st_r.tbusy & ~st_r.tskip;
    // APB slave, zero wait state.
    st_nxt.pready = 1'b1;
    st_nxt.pslverr = 1'b0;
    st_nxt.prdata = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      unique case (paddr)
        ADDR_CTRL2:  st_nxt.prdata = {16'h0000, ctrl2_r};
        ADDR_CTRL:   st_nxt.prdata = {30'h0000_0000, st_r.ctrl};
        ADDR_STATUS: st_nxt.prdata = {26'h000_0000, tx_fifo_low_flag, rx_fifo_full_flag, st_r.tx_underrun_flag,
                                      st_r.rx_overrun_flag, tx_empty_flag, st_r.rx_ready_flag};
        ADDR_RXDATA: st_nxt.prdata = {16'h0000, st_r.rxq[st_r.rrp]};
        ADDR_FIFO:   st_nxt.prdata = {8'h00, st_r.div, st_r.tcnt,
                                      st_r.rcnt, st_r.twm, st_r.rwm};
        default:     st_nxt.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && !penable)
      st_nxt.pslverr = !(paddr inside {ADDR_CTRL2, ADDR_CTRL, ADDR_STATUS,
                        ADDR_RXDATA, ADDR_TXDATA, ADDR_SKIP, ADDR_FIFO});
    if (acc && pwrite && paddr == ADDR_CTRL)
      st_nxt.ctrl = pwdata[1:0];
    if (acc && pwrite && paddr == ADDR_FIFO)
    begin
      st_nxt.rwm = pwdata[3:0];
      st_nxt.twm = pwdata[7:4];
      st_nxt.div = pwdata[23:16];
    end
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r <= '0;
      st_r.rwm <= WM_RESET;
      st_r.twm <= TX_WM_RESET;
      st_r.div <= CLK_DIV_RESET;
      st_r.pready <= 1'b1;
      st_r.rfs_o <= 1'b1;
      st_r.tfs_o <= 1'b1;
    end
    else
      st_r <= st_nxt;
  end

  assign prdata = st_r.prdata;
  assign pready = st_r.pready;
  assign pslverr = st_r.pslverr;
  assign rck_o = st_r.rck_o;
  assign rck_oe = st_r.rck_oe;
  assign rfs_o = st_r.rfs_o;
  assign rfs_oe = st_r.rfs_oe;
  assign tck_o = st_r.tck_o;
  assign tck_oe = st_r.tck_oe;
  assign tfs_o = st_r.tfs_o;
  assign tfs_oe = st_r.tfs_oe;
  assign txd_o = st_r.txd_o;
  assign txd_oe = st_r.txd_oe;
  assign irq_rx_data = st_r.irq[0];
  assign irq_rx_exc = st_r.irq[1];
  assign irq_tx_data = st_r.irq[2];
  assign irq_tx_exc = st_r.irq[3];
endmodule : sapc_top
`default_nettype wire

// >>> design/sapc_pkg.sv
// Function
// - control reg two 16 bits, port reset keeps
// - interrupts need chip priority enable
// - no fifo: ready flag raises rx irq
// - rx fifo: full flag raises rx irq
// - rx vector chosen by overrun flag
// - no fifo: empty flag raises tx irq
// - tx fifo: low flag raises tx irq
// - empty flag live; data or skip write clears
// - tx vector chosen by underrun flag
// - receiver starts at next frame sync
// - rx disable on last two bit edges drops word
// - tx enable acts at frame boundary
// - tx disable finishes word, drops output enable
// - gated clock runs while transmitting
// - rx fifo buffers eight before full
// - tx fifo accepts eight words
// - rx clock direction selects source
// - tx clock direction selects source
// - gated mode needs shared clock and rx dir
// - async mode: pins follow own direction bits
// - sync mode: rx pins free, tx pins shared
// - underrun sets and repeats last word
// - overrun sets and discards the word
package sapc_pkg;
  localparam logic [7:0]  ADDR_CTRL2  = 8'h00;
  localparam logic [7:0]  ADDR_CTRL   = 8'h04;
  localparam logic [7:0]  ADDR_STATUS = 8'h08;
  localparam logic [7:0]  ADDR_RXDATA = 8'h0C;
  localparam logic [7:0]  ADDR_TXDATA = 8'h10;
  localparam logic [7:0]  ADDR_SKIP   = 8'h14;
  localparam logic [7:0]  ADDR_FIFO   = 8'h18;
  localparam logic [15:0] CTRL2_RESET = 16'h0000;
  // Field positions of port_control_reg_two.
  localparam int B_RIE   = 0;
  localparam int B_TIE   = 1;
  localparam int B_RE    = 2;
  localparam int B_TE    = 3;
  localparam int B_RX_FIFO_ON  = 4;
  localparam int B_TX_FIFO_ON  = 5;
  localparam int B_RX_CLOCK_DIRECTION = 6;
  localparam int B_TX_CLOCK_DIRECTION = 7;
  localparam int B_RX_FRAMESYNC_DIRECTION = 8;
  localparam int B_TX_FRAMESYNC_DIRECTION = 9;
  localparam int B_SYN   = 10;
  // Field positions of the small control register.
  localparam int B_PEN   = 0;
  localparam int B_IPRE  = 1;
  // Status register bits.
  localparam int S_RDR = 0;
  localparam int S_TDE = 1;
  localparam int S_ROE = 2;
  localparam int S_TUE = 3;
  localparam int S_RFF = 4;
  localparam int S_TFE = 5;
  localparam logic [3:0] WM_RESET     = 4'h8;
  localparam logic [3:0] TX_WM_RESET  = 4'h1;
  localparam logic [7:0] CLK_DIV_RESET = 8'h03;
  localparam logic [4:0] WORD_BITS    = 5'h10;
endpackage : sapc_pkg

// >>> bench/sapc_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_monitor
  import sapc_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        por_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        rck_oe,
  input wire logic        rfs_oe,
  input wire logic        tck_oe,
  input wire logic        tfs_oe,
  input wire logic        irq_rx_data,
  input wire logic        irq_rx_exc,
  input wire logic        irq_tx_data,
  input wire logic        irq_tx_exc
);
  logic [15:0] c2_r;
  logic [1:0]  ctl_r;
  logic [3:0]  quiet_r;
  logic        wr_c;
  logic        rd_c;
  logic        ok;
  logic        ipre;
  // Access-phase strobes and the settled-configuration qualifier.
  assign wr_c = psel && penable && pwrite;
  assign rd_c = psel && penable && !pwrite;
  assign ok = ctl_r[B_PEN] && quiet_r > 4'h5;
  assign ipre = ctl_r[B_IPRE];
  // Shadow of control register two; only power-on clears it.
  always_ff @(posedge pclk or negedge por_n)
  begin
    if (!por_n)
      c2_r <= 16'h0000;
    else if (wr_c && paddr == ADDR_CTRL2)
      c2_r <= pwdata[15:0];
  end
  // Shadow of the small control register and cycles since any write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctl_r <= 2'b00;
      quiet_r <= 4'h0;
    end
    else
    begin
      if (wr_c && paddr == ADDR_CTRL)
        ctl_r <= pwdata[1:0];
      if (wr_c)
        quiet_r <= 4'h0;
      else if (quiet_r != 4'hf)
        quiet_r <= quiet_r + 4'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_irq_gate;
    irq_rx_data || irq_rx_exc || irq_tx_data || irq_tx_exc |->
      ipre || $past(ipre);
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt without chip enable");
  property p_rx_en;
    irq_rx_data || irq_rx_exc |-> c2_r[B_RIE] || $past(c2_r[B_RIE]);
  endproperty
  a_rx_en: assert property (p_rx_en)
    else $error("rx interrupt without its enable");
  property p_tx_en;
    irq_tx_data || irq_tx_exc |-> c2_r[B_TIE] || $past(c2_r[B_TIE]);
  endproperty
  a_tx_en: assert property (p_tx_en)
    else $error("tx interrupt without its enable");
  property p_rx_vec;
    not (irq_rx_data && irq_rx_exc);
  endproperty
  a_rx_vec: assert property (p_rx_vec)
    else $error("two rx vectors at once");
  property p_tx_vec;
    not (irq_tx_data && irq_tx_exc);
  endproperty
  a_tx_vec: assert property (p_tx_vec)
    else $error("two tx vectors at once");
  property p_rx_clear;
    rd_c && paddr == ADDR_RXDATA && !c2_r[B_RX_FIFO_ON] |->
      ##[1:3] !irq_rx_data && !irq_rx_exc;
  endproperty
  a_rx_clear: assert property (p_rx_clear)
    else $error("rx interrupt kept after data read");
  property p_tx_clear;
    wr_c && (paddr == ADDR_TXDATA || paddr == ADDR_SKIP) &&
      !c2_r[B_TX_FIFO_ON] |-> ##[1:3] !irq_tx_data && !irq_tx_exc;
  endproperty
  a_tx_clear: assert property (p_tx_clear)
    else $error("tx interrupt kept after data write");
  property p_c2_read;
    psel && !penable && !pwrite && paddr == ADDR_CTRL2 |=>
      prdata[10:0] == c2_r[10:0];
  endproperty
  a_c2_read: assert property (p_c2_read)
    else $error("control two read back wrong");
  property p_async;
    ok && !c2_r[B_SYN] |-> rck_oe == c2_r[B_RX_CLOCK_DIRECTION] &&
      rfs_oe == c2_r[B_RX_FRAMESYNC_DIRECTION] && tck_oe == c2_r[B_TX_CLOCK_DIRECTION] &&
      tfs_oe == c2_r[B_TX_FRAMESYNC_DIRECTION];
  endproperty
  a_async: assert property (p_async)
    else $error("async pin enables wrong");
  property p_sync;
    ok && c2_r[B_SYN] |-> !rck_oe && !rfs_oe && tck_oe == c2_r[B_TX_CLOCK_DIRECTION];
  endproperty
  a_sync: assert property (p_sync)
    else $error("sync pin enables wrong");
  property p_gated;
    ok && c2_r[B_SYN] && c2_r[B_RX_CLOCK_DIRECTION] |-> !tfs_oe;
  endproperty
  a_gated: assert property (p_gated)
    else $error("gated mode drives frame sync");
endmodule // sapc_monitor

bind sapc_top sapc_monitor i_sapc_monitor (.pclk, .presetn, .por_n,
  .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .rck_oe, .rfs_oe,
  .tck_oe, .tfs_oe, .irq_rx_data, .irq_rx_exc, .irq_tx_data, .irq_tx_exc);
`default_nettype wire

// >>> bench/sapc_codec.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_codec (
  input  wire logic        run,
  input  wire logic [15:0] word,
  output logic             sck,
  output logic             sfs,
  output logic             sdo
);
  // One frame per rising run, MSB first; clock stands still between frames.
  initial
  begin
    sck = 1'b0;
    sfs = 1'b0;
    sdo = 1'b0;
    forever
    begin
      @(posedge run);
      // Keep every pin change clear of the sampling clock edges.
      #2;
      for (int i = 15; i >= 0; i--)
      begin
        sck = 1'b1;
        sfs = (i == 15);
        sdo = word[i];
        #80 sck = 1'b0;
        #80;
      end
      // The released data line shows the inverse of its last bit.
      sfs = 1'b0;
      sdo = ~sdo;
    end
  end
endmodule // sapc_codec
`default_nettype wire

// >>> bench/sapc_top_test.sv
`timescale 1ns/1ps
`default_nettype none
module sapc_top_test;
  import sapc_pkg::*;
  logic        pclk, presetn, por_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rdat, rnd;
  logic        rck_o, rck_oe, rfs_o, rfs_oe, tck_o, tck_oe, tfs_o, tfs_oe;
  logic        txd_o, txd_oe, serr, run, sck, sfs, sdo;
  logic        irq_rx_data, irq_rx_exc, irq_tx_data, irq_tx_exc;
  logic        rck_i, rfs_i, tck_i, tfs_i, rxd_i;
  logic [15:0] word;
  logic [3:0]  irqs;
  logic [10:0] c2_m;
  int          n_errors, checks;
  logic [15:0] q[$];
  // Pin levels: the design wins where it drives, else the codec.
  assign rck_i = rck_oe ? rck_o : sck;
  assign tck_i = tck_oe ? tck_o : sck;
  assign rfs_i = rfs_oe ? rfs_o : sfs;
  assign tfs_i = tfs_oe ? tfs_o : sfs;
  assign rxd_i = sdo;
  assign irqs = {irq_tx_exc, irq_tx_data, irq_rx_exc, irq_rx_data};
  sapc_top #(.DEPTH(8)) i_sapc_top (.pclk, .presetn, .por_n, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rck_i,
    .rck_o, .rck_oe, .rfs_i, .rfs_o, .rfs_oe, .tck_i, .tck_o, .tck_oe,
    .tfs_i, .tfs_o, .tfs_oe, .rxd_i, .txd_o, .txd_oe, .irq_rx_data,
    .irq_rx_exc, .irq_tx_data, .irq_tx_exc);
  sapc_codec i_sapc_codec (.run, .word, .sck, .sfs, .sdo);
  // Free-running bench clock.
  initial
  begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected pin enables from syn, tx_framesync_direction, rx_framesync_direction, tx_clock_direction, rx_clock_direction.
  function automatic logic [31:0] pins(input logic [4:0] m);
    return {28'h000_0000, !m[4] & m[0], !m[4] & m[2], m[1],
            m[4] ? !m[0] & m[3] : m[3]};
  endfunction
  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer; data and error are taken at the pready edge.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 100)
    begin
      n++;
      @(posedge pclk);
    end
    rdat = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
    if (n == 100)
    begin
      n_errors++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    if (a == ADDR_CTRL2)
      c2_m = d[10:0];
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk("read data", {16'h0000, e}, {16'h0000, rdat[15:0]});
  endtask
  // Waits a bounded time for one interrupt line to reach a level.
  task automatic wt(input int k, input logic v);
    int n;
    n = 0;
    while (irqs[k] !== v && n < 3000)
    begin
      n++;
      @(posedge pclk);
    end
    chk("interrupt", 32'(v), 32'(irqs[k]));
    if (n == 3000)
      complete_run();
  endtask
  task automatic rst(input logic p);
    presetn <= 1'b0;
    por_n <= p;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    if (!p)
      c2_m = 11'h000;
  endtask
  // Sends one word from the codec; the model keeps one held word.
  task automatic send();
    repeat (24) @(posedge pclk);
    rnd = lfsr(rnd);
    word <= rnd[15:0];
    @(posedge pclk);
    run <= 1'b1;
    @(posedge pclk);
    run <= 1'b0;
    if (q.size() == 0)
      q.push_back(rnd[15:0]);
  endtask
  // Main sequence.
  initial
  begin
    {presetn, por_n, psel, penable, pwrite, run} = 6'b000000;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    word = 16'h0000;
    rnd = 32'haa75_5afd;
    n_errors = 0;
    checks = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    por_n <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CTRL2, CTRL2_RESET);
    apb(1'b0, 8'h1c, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, 32'(serr));
    rnd = lfsr(rnd);
    wr(ADDR_CTRL2, rnd & 32'h0000_07ff);
    rst(1'b1);
    rd(ADDR_CTRL2, 16'(c2_m));
    rst(1'b0);
    rd(ADDR_CTRL2, 16'(c2_m));
    wr(ADDR_CTRL, 32'h0000_0001);
    for (int m = 0; m < 32; m++)
    begin
      wr(ADDR_CTRL2, 32'(m) << 6);
      repeat (8) @(posedge pclk);
      chk("pin enables", pins(5'(m)),
          {28'h000_0000, rck_oe, rfs_oe, tck_oe, tfs_oe});
    end
    wr(ADDR_CTRL, 32'h0000_0003);
    wr(ADDR_CTRL2, 32'h0000_0282);
    repeat (8) @(posedge pclk);
    chk("tx irq idle", 32'h0, 32'(irq_tx_data));
    wr(ADDR_TXDATA, rnd & 32'h0000_ffff);
    wr(ADDR_CTRL2, 32'h0000_028a);
    wt(2, 1'b1);
    chk("tx output enable", 32'h0000_0001, 32'(txd_oe));
    chk("tx first bit", 32'(rnd[15]), 32'(txd_o));
    wt(3, 1'b1);
    wr(ADDR_CTRL, 32'h0000_0001);
    repeat (3) @(posedge pclk);
    chk("masked irqs", 32'h0, 32'(irqs));
    wr(ADDR_CTRL, 32'h0000_0003);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    wr(ADDR_SKIP, 32'h0000_0000);
    @(posedge pclk);
    chk("tx irqs cleared", 32'h0, 32'(irqs[3:2]));
    wr(ADDR_CTRL2, 32'h0000_0000);
    wr(ADDR_CTRL2, 32'h0000_0005);
    send();
    wt(0, 1'b1);
    rd(ADDR_RXDATA, q.pop_front());
    @(posedge pclk);
    chk("rx irq cleared", 32'h0, 32'(irq_rx_data));
    send();
    wt(0, 1'b1);
    send();
    wt(1, 1'b1);
    apb(1'b0, ADDR_STATUS, 32'h0000_0000);
    rd(ADDR_RXDATA, q.pop_front());
    complete_run();
  end
endmodule // sapc_top_test
`default_nettype wire
